// ===== include/sfpew_defs.svh
// constants for the serial flash program, erase and wrap block
// Function
// - 77H, 24 dummy bits, 8 wrap bits, select high latches the wrap byte
// - wrap-disable clear: quad reads wrap in 8/16/32/64-byte page sections
// - stored wrap setting applies to every later quad I/O read
// - page program runs only when the write latch was set before
// - program data past the page end wraps to the same page start
// - more than 256 data bytes: only the last 256 are programmed
// - fewer than 256 bytes: other bytes of the page stay unchanged
// - program runs only if select rises on a data byte boundary
// - busy bit reads 1 during self-timed cycle, status reads allowed
// - write latch is cleared before the self-timed cycle ends
// - page program into a protected page is not executed
// - 32H needs quad enable; address and data travel on four lines
// - 20H erases the whole sector holding the given address
// - erase runs only if select rises right after the third address byte
// - sector erase into a protected sector is ignored
// - 52H erases the 32KB block holding the address, same framing
// - D8H erases the 64KB block holding the address, same framing
// - block erase into a protected block is not executed
// - wrapped read starts at address, wraps at section end until select high
`ifndef SFPEW_DEFS_SVH
`define SFPEW_DEFS_SVH
// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define SFPEW_OP_WRITE_UNLOCK_CMD 8'h06
`define SFPEW_OP_RDSR_LO 8'h05
`define SFPEW_OP_RDSR_HI 8'h35
`define SFPEW_OP_PP 8'h02
`define SFPEW_OP_QPP 8'h32
`define SFPEW_OP_SE 8'h20
`define SFPEW_OP_HALF_BLOCK_CLEAR_CMD 8'h52
`define SFPEW_OP_FULL_BLOCK_CLEAR_CMD 8'hD8
`define SFPEW_OP_WRAP 8'h77
`define SFPEW_OP_QIOR 8'hEB
// ---------------------------------------------------------------
// register map and fields
// ---------------------------------------------------------------
`define SFPEW_REG_STATUS 8'h00
`define SFPEW_REG_CONFIG 8'h04
`define SFPEW_ST_CIP 0
`define SFPEW_ST_WEL 1
`define SFPEW_ST_WDIS 2
`define SFPEW_ST_WLEN 3
`define SFPEW_CF_BP 0
`define SFPEW_CF_QE 8
`define SFPEW_RESP_OKAY 2'h0
`define SFPEW_RESP_SLVERR 2'h2
// ---------------------------------------------------------------
// sizes and timing
// ---------------------------------------------------------------
`define SFPEW_PAGE_LEN 20'h00100
`define SFPEW_SECT_LEN 20'h01000
`define SFPEW_B32_LEN 20'h08000
`define SFPEW_B64_LEN 20'h10000
`define SFPEW_PROG_CYC 2000
`define SFPEW_ERASE_CYC 4000
`define SFPEW_MEM_AW 12
`endif

// ===== include/sfpew_pkg.sv
// types for the serial flash program, erase and wrap block
package sfpew_pkg;
  typedef enum logic [3:0] {
    PH_CMD, PH_ADDR, PH_DATA, PH_WRAP, PH_STAT,
    PH_MODE, PH_DUMMY, PH_RDATA, PH_SKIP
  } sfpew_phase_t;
  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE_UNLOCK_CMD, OP_PROG, OP_ERASE, OP_WRAP, OP_READ
  } sfpew_op_t;
  // four-line data pins, output side
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } sfpew_qline_t;
  typedef struct packed {
    logic cs_m, cs_s, cs_p;
    logic ck_m, ck_s, ck_p;
    logic [3:0] io_m, io_s;
    sfpew_phase_t ph;
    sfpew_op_t op;
    logic quad, shi, done;
    logic [1:0] esz;
    logic [3:0] bits;
    logic [2:0] bytes;
    logic [7:0] sh, wbyte, dcnt, osh;
    logic [2:0] ocnt;
    logic [23:0] addr, raddr;
    logic [255:0] mask;
    sfpew_qline_t q;
    logic write_latch, qe, wdis;
    logic [1:0] wlen;
    logic [4:0] bp;
    logic busy, bprog;
    logic [23:0] base;
    logic [19:0] len, wcnt, wend;
    logic awrdy, bvalid, arrdy, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } sfpew_state_t;
endpackage

// ===== src/sfpew_flash.sv
// serial flash command engine: program, erase, wrap and AXI4-Lite view
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "sfpew_defs.svh"
module sfpew_flash #(
  parameter int MEM_AW = `SFPEW_MEM_AW,
  parameter int PROG_CYC = `SFPEW_PROG_CYC,
  parameter int ERASE_CYC = `SFPEW_ERASE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] qline_i,
  output sfpew_pkg::sfpew_qline_t qline_out
);
  import sfpew_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  sfpew_state_t st_q;
  sfpew_state_t st_d;
  logic [7:0] mem [0:(1<<MEM_AW)-1];
  logic [7:0] pbuf [0:255];
  logic mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic buf_we;
  logic [7:0] buf_wa;
  logic [7:0] buf_wd;
  logic rise, fall, cs_up, cs_dn;

  // array starts erased, as a blank part would
  initial begin
    for (int i = 0; i < (1<<MEM_AW); i++) begin
      mem[i] = 8'hFF;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // protect field: bits 2..0 size, bit 4 picks bottom instead of top
  function automatic logic prot(input logic [4:0] bp, input logic [23:0] a);
    logic [2:0] blk;
    blk = bp[4] ? ~a[18:16] : a[18:16];
    case (bp[2:0])
      3'h0: prot = 1'b0;
      3'h1: prot = (blk == 3'h7);
      3'h2: prot = (blk >= 3'h6);
      3'h3: prot = (blk >= 3'h4);
      default: prot = 1'b1;
    endcase
  endfunction

  // next read address, kept inside the wrap section when enabled
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic dis,
                                      input logic [1:0] wl);
    logic [7:0] m;
    logic [7:0] inc;
    m = 8'(8'h08 << wl) - 8'h01;
    inc = a[7:0] + 8'h01;
    if (dis) begin
      nxt = a + 24'h000001;
    end else begin
      nxt = {a[23:8], (a[7:0] & ~m) | (inc & m)};
    end
  endfunction

  function automatic logic [7:0] stat_lo(input sfpew_state_t s);
    stat_lo = {1'b0, s.bp, s.write_latch, s.busy};
  endfunction

  // ---------------------------------------------------------------
  // link edges, seen on the synchronised copies only
  // ---------------------------------------------------------------
  assign rise = !st_q.ck_p && st_q.ck_s && !st_q.cs_s;
  assign fall = st_q.ck_p && !st_q.ck_s && !st_q.cs_s;
  assign cs_up = !st_q.cs_p && st_q.cs_s;
  assign cs_dn = st_q.cs_p && !st_q.cs_s;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [7:0] nsh;
    logic [3:0] nbits;
    logic [7:0] b;
    logic [23:0] wa;
    logic wr_ok, rd_ok;
    nsh = 8'h00;
    nbits = 4'h0;
    b = 8'h00;
    wa = 24'h000000;
    wr_ok = 1'b0;
    rd_ok = 1'b0;
    st_d = st_q;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = 8'h00;
    buf_we = 1'b0;
    buf_wa = 8'h00;
    buf_wd = 8'h00;

    // two-flop synchronisers, third flop only for edge finding
    st_d.cs_m = cs_n;
    st_d.cs_s = st_q.cs_m;
    st_d.cs_p = st_q.cs_s;
    st_d.ck_m = sclk;
    st_d.ck_s = st_q.ck_m;
    st_d.ck_p = st_q.ck_s;
    st_d.io_m = qline_i;
    st_d.io_s = st_q.io_m;

    // select falling starts a fresh command frame
    if (cs_dn) begin
      st_d.ph = PH_CMD;
      st_d.op = OP_NONE;
      st_d.quad = 1'b0;
      st_d.done = 1'b0;
      st_d.bits = 4'h0;
      st_d.bytes = 3'h0;
      st_d.dcnt = 8'h00;
      st_d.mask = '0;
      st_d.ocnt = 3'h0;
    end

    // sample on the link clock rising edge
    if (rise) begin
      nsh = st_q.quad ? {st_q.sh[3:0], st_q.io_s} : {st_q.sh[6:0], st_q.io_s[0]};
      nbits = st_q.bits + (st_q.quad ? 4'h4 : 4'h1);
      st_d.sh = nsh;
      st_d.done = 1'b0; // a bit past the boundary aborts
      st_d.bits = nbits;
      if (nbits == 4'h8) begin
        st_d.bits = 4'h0;
        case (st_q.ph)
          PH_CMD: begin
            st_d.ph = PH_SKIP;
            case (nsh)
              `SFPEW_OP_WRITE_UNLOCK_CMD: begin
                st_d.op = OP_WRITE_UNLOCK_CMD;
                st_d.done = 1'b1;
              end
              `SFPEW_OP_RDSR_LO, `SFPEW_OP_RDSR_HI: begin
                st_d.ph = PH_STAT;
                st_d.shi = (nsh == `SFPEW_OP_RDSR_HI);
              end
              `SFPEW_OP_PP, `SFPEW_OP_QPP: begin
                // quad form needs the enable bit
                if (!st_q.busy && (nsh == `SFPEW_OP_PP || st_q.qe)) begin
                  st_d.ph = PH_ADDR;
                  st_d.op = OP_PROG;
                  st_d.quad = (nsh == `SFPEW_OP_QPP);
                end
              end
              `SFPEW_OP_SE, `SFPEW_OP_HALF_BLOCK_CLEAR_CMD, `SFPEW_OP_FULL_BLOCK_CLEAR_CMD: begin
                if (!st_q.busy) begin
                  st_d.ph = PH_ADDR;
                  st_d.op = OP_ERASE;
                  st_d.esz = (nsh == `SFPEW_OP_SE) ? 2'h0 :
                             (nsh == `SFPEW_OP_HALF_BLOCK_CLEAR_CMD) ? 2'h1 : 2'h2;
                end
              end
              `SFPEW_OP_WRAP: begin
                st_d.ph = PH_WRAP;
                st_d.op = OP_WRAP;
              end
              `SFPEW_OP_QIOR: begin
                // reads are refused while the array is busy
                if (st_q.qe && !st_q.busy) begin
                  st_d.ph = PH_ADDR;
                  st_d.op = OP_READ;
                  st_d.quad = 1'b1;
                end
              end
              default: st_d.ph = PH_SKIP;
            endcase
          end
          PH_ADDR: begin
            st_d.addr = {st_q.addr[15:0], nsh};
            st_d.bytes = st_q.bytes + 3'h1;
            if (st_q.bytes == 3'h2) begin
              st_d.bytes = 3'h0;
              case (st_q.op)
                OP_PROG: st_d.ph = PH_DATA;
                OP_ERASE: begin
                  st_d.ph = PH_SKIP;
                  st_d.done = 1'b1;
                end
                default: st_d.ph = PH_MODE;
              endcase
            end
          end
          PH_DATA: begin
            // ring of 256: late bytes overwrite early ones
            buf_we = 1'b1;
            buf_wa = st_q.addr[7:0] + st_q.dcnt;
            buf_wd = nsh;
            st_d.mask[buf_wa] = 1'b1;
            st_d.dcnt = st_q.dcnt + 8'h01;
            st_d.done = 1'b1;
          end
          PH_WRAP: begin
            st_d.bytes = st_q.bytes + 3'h1;
            if (st_q.bytes == 3'h3) begin
              st_d.wbyte = nsh;
              st_d.done = 1'b1;
              st_d.ph = PH_SKIP;
            end
          end
          PH_MODE: st_d.ph = PH_DUMMY;
          PH_DUMMY: begin
            // two quad bytes make the four dummy clocks
            st_d.bytes = st_q.bytes + 3'h1;
            if (st_q.bytes == 3'h1) begin
              st_d.ph = PH_RDATA;
              st_d.raddr = st_q.addr;
              st_d.ocnt = 3'h0;
            end
          end
          default: st_d.ph = st_q.ph;
        endcase
      end
    end

    // shift out on the falling edge so the host samples on the rising one
    if (fall && st_q.ph == PH_STAT) begin
      st_d.q.oe_n[1] = 1'b0;
      if (st_q.ocnt == 3'h0) begin
        b = st_q.shi ? {6'h00, st_q.qe, 1'b0} : stat_lo(st_q);
        st_d.q.o[1] = b[7];
        st_d.osh = {b[6:0], 1'b0};
        st_d.ocnt = 3'h7;
      end else begin
        st_d.q.o[1] = st_q.osh[7];
        st_d.osh = {st_q.osh[6:0], 1'b0};
        st_d.ocnt = st_q.ocnt - 3'h1;
      end
    end
    if (fall && st_q.ph == PH_RDATA) begin
      st_d.q.oe_n = 4'h0;
      if (st_q.ocnt == 3'h0) begin
        b = mem[st_q.raddr[MEM_AW-1:0]];
        st_d.q.o = b[7:4];
        st_d.osh = {b[3:0], 4'h0};
        st_d.ocnt = 3'h1;
        st_d.raddr = nxt(st_q.raddr, st_q.wdis, st_q.wlen);
      end else begin
        st_d.q.o = st_q.osh[7:4];
        st_d.ocnt = 3'h0;
      end
    end

    // select rising: release the lines and run a complete command
    if (cs_up) begin
      st_d.q.oe_n = 4'hF;
      st_d.ph = PH_SKIP;
      if (st_q.done) begin
        case (st_q.op)
          OP_WRITE_UNLOCK_CMD: st_d.write_latch = 1'b1;
          OP_WRAP: begin
            st_d.wdis = st_q.wbyte[4];
            st_d.wlen = st_q.wbyte[6:5];
          end
          OP_PROG: begin
            if (st_q.write_latch && !st_q.busy && !prot(st_q.bp, st_q.addr)) begin
              st_d.busy = 1'b1;
              st_d.bprog = 1'b1;
              st_d.write_latch = 1'b0;
              st_d.base = {st_q.addr[23:8], 8'h00};
              st_d.len = `SFPEW_PAGE_LEN;
              st_d.wend = `SFPEW_PAGE_LEN + 20'(PROG_CYC) - 20'h1;
              st_d.wcnt = 20'h0;
            end
          end
          OP_ERASE: begin
            if (st_q.write_latch && !st_q.busy && !prot(st_q.bp, st_q.addr)) begin
              st_d.busy = 1'b1;
              st_d.bprog = 1'b0;
              st_d.write_latch = 1'b0;
              st_d.wcnt = 20'h0;
              case (st_q.esz)
                2'h0: begin
                  st_d.base = {st_q.addr[23:12], 12'h000};
                  st_d.len = `SFPEW_SECT_LEN;
                end
                2'h1: begin
                  st_d.base = {st_q.addr[23:15], 15'h0000};
                  st_d.len = `SFPEW_B32_LEN;
                end
                default: begin
                  st_d.base = {st_q.addr[23:16], 16'h0000};
                  st_d.len = `SFPEW_B64_LEN;
                end
              endcase
              st_d.wend = st_d.len + 20'(ERASE_CYC) - 20'h1;
            end
          end
          default: st_d.op = OP_NONE;
        endcase
      end
    end

    // self-timed cycle: walk the region, then hold busy for the rest
    if (st_q.busy) begin
      st_d.wcnt = st_q.wcnt + 20'h1;
      if (st_q.wcnt < st_q.len) begin
        if (st_q.bprog) begin
          wa = st_q.base | {16'h0000, st_q.wcnt[7:0]};
          mem_we = st_q.mask[st_q.wcnt[7:0]];
          mem_wd = mem[wa[MEM_AW-1:0]] & pbuf[st_q.wcnt[7:0]];
        end else begin
          wa = st_q.base + {4'h0, st_q.wcnt};
          mem_we = 1'b1;
          mem_wd = 8'hFF;
        end
        mem_wa = wa[MEM_AW-1:0];
      end
      if (st_q.wcnt == st_q.wend) begin
        st_d.busy = 1'b0;
      end
    end

    // AXI4-Lite write: address and data taken together
    wr_ok = (s_axi_awaddr == `SFPEW_REG_CONFIG);
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.awrdy) begin
      st_d.awrdy = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = wr_ok ? `SFPEW_RESP_OKAY : `SFPEW_RESP_SLVERR;
      if (wr_ok && s_axi_wstrb[0]) begin
        st_d.bp = s_axi_wdata[`SFPEW_CF_BP +: 5];
      end
      if (wr_ok && s_axi_wstrb[1]) begin
        st_d.qe = s_axi_wdata[`SFPEW_CF_QE];
      end
    end else if (s_axi_awvalid && s_axi_wvalid && !st_q.bvalid) begin
      st_d.awrdy = 1'b1;
    end

    // AXI4-Lite read: status shows live engine state
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (st_q.arrdy) begin
      st_d.arrdy = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.rdata = 32'h00000000;
      rd_ok = 1'b1;
      if (s_axi_araddr == `SFPEW_REG_STATUS) begin
        st_d.rdata[`SFPEW_ST_CIP] = st_q.busy;
        st_d.rdata[`SFPEW_ST_WEL] = st_q.write_latch;
        st_d.rdata[`SFPEW_ST_WDIS] = st_q.wdis;
        st_d.rdata[`SFPEW_ST_WLEN +: 2] = st_q.wlen;
      end else if (s_axi_araddr == `SFPEW_REG_CONFIG) begin
        st_d.rdata[`SFPEW_CF_BP +: 5] = st_q.bp;
        st_d.rdata[`SFPEW_CF_QE] = st_q.qe;
      end else begin
        rd_ok = 1'b0;
      end
      st_d.rresp = rd_ok ? `SFPEW_RESP_OKAY : `SFPEW_RESP_SLVERR;
    end else if (s_axi_arvalid && !st_q.rvalid) begin
      st_d.arrdy = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // one state register; wrap defaults to disabled, lines released
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
      st_q.cs_m <= 1'b1;
      st_q.cs_s <= 1'b1;
      st_q.cs_p <= 1'b1;
      st_q.ph <= PH_SKIP;
      st_q.q.oe_n <= 4'hF;
      st_q.wdis <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // arrays keep no reset; written only from the engine above
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (buf_we) begin
      pbuf[buf_wa] <= buf_wd;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from the state register
  // ---------------------------------------------------------------
  assign s_axi_awready = st_q.awrdy;
  assign s_axi_wready = st_q.awrdy;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arrdy;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;
  assign qline_out = st_q.q;
endmodule

// ===== verification/sfpew_flash_monitor.sv
// checker for the flash block's bus answers and pin drive
`timescale 1ns/1ps
module sfpew_flash_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic cs_n,
  input wire sfpew_pkg::sfpew_qline_t qline_out
);
  import sfpew_pkg::*;
  // ---------------------------------------------
  // properties, all in the one clock domain
  // ---------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
    else $error("write readies not paired");
  a_write_answer: assert property ($rose(s_axi_awvalid) && s_axi_wvalid && !s_axi_bvalid
    |=> s_axi_awready ##1 s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  a_read_pulse: assert property (s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_status_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> s_axi_rdata[31:5] == 27'h0 && s_axi_rresp == 2'h0)
    else $error("status read malformed");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h04
    |=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_status_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h00
    |=> s_axi_bvalid && s_axi_bresp == 2'h2)
    else $error("status write not refused");
  a_lines_idle: assert property (cs_n [*6] |-> qline_out.oe_n == 4'hF)
    else $error("lines driven while idle");
  a_quad_all: assert property (!qline_out.oe_n[0] |-> qline_out.oe_n == 4'h0)
    else $error("quad drive incomplete");
  // main scenarios reached
  c_busy_seen: cover property (s_axi_rvalid && s_axi_rdata[0]);
  c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_line_out: cover property (!qline_out.oe_n[1]);
endmodule
bind sfpew_flash sfpew_flash_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .cs_n, .qline_out);

// ===== verification/sfpew_host.sv
// host controller model driving select, link clock and lines
`timescale 1ns/1ps
module sfpew_host (
  input wire logic aclk,
  output logic cs_n,
  output logic sclk,
  output wire logic [3:0] qline_i,
  input wire sfpew_pkg::sfpew_qline_t qline_out
);
  import sfpew_pkg::*;
  logic [3:0] hl;
  // wire level: device wins where it drives, else the host value
  assign qline_i = (qline_out.oe_n & hl) | (~qline_out.oe_n & qline_out.o);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    hl = 4'hA;
  end
  // ---------------------------------------------
  // one frame, mode 0, clock still outside it
  // ---------------------------------------------
  task automatic frame(input logic [7:0] q[$], input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    cs_n <= 1'b0;
    repeat (4) @(posedge aclk);
    for (int i = 0; i < nbits; i++) begin
      hl[0] <= q[i / 8][7 - i % 8];
      repeat (4) @(posedge aclk);
      sclk <= 1'b1;
      repeat (4) @(posedge aclk);
      // sampled late: device output lags the fall by a few cycles
      rx = {rx[6:0], qline_ow()};
      sclk <= 1'b0;
    end
    repeat (4) @(posedge aclk);
    cs_n <= 1'b1;
    hl <= ~hl;
    repeat (8) @(posedge aclk);
  endtask
  function automatic logic qline_ow();
    return qline_i[1];
  endfunction
endmodule

// ===== verification/tb_serial_flash_program_erase_wrap.sv
// self-checking bench for the flash program, erase and wrap block
`timescale 1ns/1ps
module tb_serial_flash_program_erase_wrap;
  import sfpew_pkg::*;
  typedef struct packed {
    logic [7:0] w;
    logic [2:0] e;
  } sfpew_row_t;
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, cs_n, sclk;
  logic [7:0] awa, ara, rx;
  logic [31:0] wd, rd, d;
  logic [3:0] ws, qi;
  logic [1:0] bresp, rresp, r;
  sfpew_qline_t qo;
  int bad_count, tests_run;
  // wrap byte and the status bits 4:2 it should leave
  sfpew_row_t rows [6] = '{'{8'h00, 3'b000}, '{8'h20, 3'b010}, '{8'h40, 3'b100},
    '{8'h60, 3'b110}, '{8'h70, 3'b111}, '{8'h10, 3'b001}};
  logic [7:0] prot [4] = '{8'h02, 8'h20, 8'h52, 8'hD8};
  sfpew_flash #(.PROG_CYC(1), .ERASE_CYC(1)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rd), .s_axi_rresp(rresp), .cs_n(cs_n), .sclk(sclk), .qline_i(qi), .qline_out(qo));
  sfpew_host u_host (.aclk(aclk), .cs_n(cs_n), .sclk(sclk), .qline_i(qi), .qline_out(qo));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ---------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    end_of_test();
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    int n;
    n = 0;
    awa <= a;
    wd <= v;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (awr !== 1'b1 && n < 50);
    awv <= 1'b0;
    wv <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (bv !== 1'b1 && n < 50);
    // bready stays high, so the next write never re-raises it in this step
    rs = bresp;
    if (n >= 50) give_up();
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arr !== 1'b1 && n < 50);
    arv <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (rv !== 1'b1 && n < 50);
    v = rd;
    rs = rresp;
    if (n >= 50) give_up();
  endtask
  task automatic st(input logic [31:0] e);
    axi_rd(8'h00, d, r);
    check(d, e);
  endtask
  task automatic send(input logic [7:0] q[$], input int nb);
    u_host.frame(q, nb, rx);
    repeat (10) @(posedge aclk);
  endtask
  // polling keeps the wait bounded by a count of status reads
  task automatic wait_idle(input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      axi_rd(8'h00, d, r);
      if (d[0] === 1'b0) break;
    end
    if (k >= lim) give_up();
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    aresetn = 1'b0;
    {awv, wv, br, arv, rr} = 5'h00;
    awa = 8'h00;
    ara = 8'h00;
    wd = 32'h0;
    ws = 4'h0;
    bad_count = 0;
    tests_run = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    st(32'h4);
    axi_rd(8'h04, d, r);
    check(d, 32'h0);
    axi_rd(8'h08, d, r);
    check({r, d[29:0]}, 32'h80000000);
    axi_wr(8'h00, 32'hFF, 4'hF, r);
    check(r, 32'h2);
    foreach (rows[i]) begin
      send({8'h77, 8'h00, 8'h00, 8'h00, rows[i].w}, 40);
      axi_rd(8'h00, d, r);
      check(d[4:2], rows[i].e);
    end
    // frame cut short leaves the wrap setting alone
    send({8'h77, 8'h00, 8'h00, 8'h00, 8'h60}, 36);
    st(32'h4);
    send({8'h02, 8'h00, 8'h01, 8'h00, 8'h5A}, 40);
    st(32'h4);
    send({8'h06}, 8);
    st(32'h6);
    send({8'h02, 8'h00, 8'h01, 8'h00, 8'h5A, 8'hA5}, 44);
    st(32'h6);
    send({8'h02, 8'h00, 8'h01, 8'hF0, 8'h5A, 8'hA5}, 48);
    st(32'h5);
    u_host.frame({8'h05, 8'h00}, 16, rx);
    check(rx, 32'h01);
    wait_idle(200);
    st(32'h4);
    send({8'h06}, 8);
    send({8'h20, 8'h00, 8'h21, 8'h23}, 32);
    st(32'h5);
    send({8'h06}, 8);
    send({8'h02, 8'h00, 8'h02, 8'h00, 8'h11}, 40);
    wait_idle(2000);
    st(32'h6);
    send({8'h20, 8'h00, 8'h20, 8'h00}, 24);
    st(32'h6);
    send({8'h20, 8'h00, 8'h20, 8'h00, 8'hFF}, 36);
    st(32'h6);
    send({8'h32, 8'h00, 8'h00, 8'h00}, 32);
    st(32'h6);
    // strobes pick the byte lanes of the configuration word
    axi_wr(8'h04, 32'h104, 4'h2, r);
    axi_rd(8'h04, d, r);
    check(d, 32'h100);
    axi_wr(8'h04, 32'h1FF, 4'h1, r);
    axi_rd(8'h04, d, r);
    check(d, 32'h11F);
    foreach (prot[i]) begin
      send({prot[i], 8'h01, 8'h23, 8'h40, 8'h5A}, prot[i] == 8'h02 ? 40 : 32);
      st(32'h6);
    end
    axi_wr(8'h04, 32'h100, 4'h1, r);
    send({8'h52, 8'h01, 8'h23, 8'h45}, 32);
    st(32'h5);
    // a half block walks 32768 cycles; each poll takes about three
    wait_idle(12000);
    st(32'h4);
    end_of_test();
  end
endmodule
